//--- lsrb_top.sv
/*
 * Relay status bank and positional data registers of a four-loop
 * temperature controller, as an AXI4-Lite slave.
 * Assumes loop and system status inputs synchronous to aclk.
 */
// Contract
// - Sequential read without position returns consecutive words from position 1.
// - Sequential write without position stores consecutive words from position 1.
// - Relay status query returns relays 01 to 16 as one word.
// - Off-to-on change of an interrupt-capable relay raises an interrupt.
// - Module ready relay X16 reads 0 during startup, 1 afterwards.
// - Startup completes within about 2 s; writes meanwhile may be dropped.
// - Writes before ready may be replaced by defaults during initialization.
// - Register reads before ready carry no guaranteed value.
// - Seven relays per loop, heat and cool output relays among them, four system relays.
// - Loops start at X01, X09, X17, X25 in fixed field order.
// - Alarm relays read 1 while the alarm is active, else 0.
// - Fault relay reads 1 on burnout, converter or other fatal error.
// - Command done relay X08 reads 0 while busy, 1 when done.
// - Setup relay X24 reads 1 in setup mode, 0 in normal mode.
// - Save done relay X32 reads 1 only after the save completes.
// - Only alarm, tuning done, fault and system relays interrupt.
// - Relays refresh once per input sampling period, 100 or 200 ms; module ready relay X16 here follows ready at once.
// - Heat and cool relays refresh at max(cycle time/1000, 10 ms).
`timescale 1ns/1ps
module lsrb_top #(
  parameter int NUM_POS = lsrb_pkg::NUM_POS,
  parameter int MS_CYCLES = lsrb_pkg::MS_CYCLES,
  parameter int STARTUP_MS = lsrb_pkg::STARTUP_MS
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Loop and system status
  input wire lsrb_pkg::lsrb_loop_s [3:0] loop_in,
  input wire logic command_done,
  input wire logic setup_mode,
  input wire logic setpoint_save_done,
  // Status toward the CPU
  output logic module_ready,
  output logic [31:0] irq_event,
  output logic irq_req
);
  localparam int PW = $clog2(NUM_POS + 1);
  localparam int MW = $clog2(MS_CYCLES + 1);
  localparam int BW = $clog2(STARTUP_MS + 1);
  // ******************
  // Startup sequencing
  // ******************
  lsrb_pkg::lsrb_state_e state;
  logic [MW-1:0] ms_cnt;
  logic ms_tick;
  logic [BW-1:0] boot_ms;
  logic ready;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ms_cnt <= '0;
      ms_tick <= 1'b0;
    end else begin
      ms_tick <= (ms_cnt == MW'(MS_CYCLES - 1));
      ms_cnt <= (ms_cnt == MW'(MS_CYCLES - 1)) ? '0 : ms_cnt + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= lsrb_pkg::ST_INIT;
      boot_ms <= '0;
    end else begin
      case (state)
        lsrb_pkg::ST_INIT: begin
          if (ms_tick) begin
            boot_ms <= boot_ms + 1'b1;
            if (boot_ms == BW'(STARTUP_MS - 1)) begin
              state <= lsrb_pkg::ST_READY;
            end
          end
        end
        lsrb_pkg::ST_READY: state <= lsrb_pkg::ST_READY;
        default: state <= lsrb_pkg::ST_INIT;
      endcase
    end
  end

  assign ready = (state == lsrb_pkg::ST_READY);
  assign module_ready = ready;

  // ******************
  // Control registers
  // ******************
  logic [15:0] ctrl;
  logic [15:0] out_cycle;

  // ******************
  // Refresh timing
  // ******************
  logic [7:0] in_ms;
  logic [7:0] in_period;
  logic in_tick;
  logic [15:0] out_ms;
  logic [15:0] out_period;
  logic out_tick;
  assign in_period = ctrl[lsrb_pkg::CTRL_SLOW_BIT] ? 8'(lsrb_pkg::SAMPLE_SLOW_MS) :
                     8'(lsrb_pkg::SAMPLE_FAST_MS);
  // Cycle time is held in seconds, so its thousandth in ms is the same number
  assign out_period = (out_cycle > 16'(lsrb_pkg::OUT_MIN_MS)) ? out_cycle :
                      16'(lsrb_pkg::OUT_MIN_MS);
  assign in_tick = ms_tick && (in_ms >= in_period - 8'h01);
  assign out_tick = ms_tick && (out_ms >= out_period - 16'h0001);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_ms <= '0;
    end else if (ms_tick) begin
      in_ms <= in_tick ? 8'h00 : in_ms + 8'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_ms <= '0;
    end else if (ms_tick) begin
      out_ms <= out_tick ? 16'h0000 : out_ms + 16'h0001;
    end
  end

  // ******************
  // Relay image
  // ******************
  logic [31:0] live;
  logic [31:0] relay_q;
  logic [31:0] relay;
  logic [31:0] relay_prev;
  logic [3:0] sysv;
  assign sysv = {setpoint_save_done, setup_mode, ready, command_done};
  generate
    for (genvar l = 0; l < 4; l++) begin : g_loop
      assign live[8*l +: 7] = loop_in[l];
      assign live[8*l + 7] = sysv[l];
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      relay_q <= '0;
    end else begin
      if (in_tick) begin
        relay_q <= (live & ~lsrb_pkg::HC_MASK) | (relay_q & lsrb_pkg::HC_MASK);
      end
      if (out_tick) begin
        relay_q[31:0] <= ((in_tick ? live : relay_q) & ~lsrb_pkg::HC_MASK)
                         | (live & lsrb_pkg::HC_MASK);
      end
    end
  end

  // Ready is shown at once so the CPU never waits a sample period for it
  assign relay = (relay_q & ~lsrb_pkg::READY_MASK) | (32'(ready) << lsrb_pkg::READY_BIT);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      relay_prev <= '0;
      irq_event <= '0;
      irq_req <= 1'b0;
    end else begin
      relay_prev <= relay;
      irq_event <= relay & ~relay_prev & lsrb_pkg::IRQ_CAPABLE;
      irq_req <= |(relay & ~relay_prev & lsrb_pkg::IRQ_CAPABLE);
    end
  end

  // ******************
  // AXI write channel
  // ******************
  logic aw_hold;
  logic [11:0] aw_addr;
  logic w_hold;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic wr_win;
  logic wr_hit;
  logic [7:0] wr_pos;
  logic wr_seq;
  logic wr_restart;
  assign s_axi_awready = !aw_hold && !s_axi_bvalid;
  assign s_axi_wready = !w_hold && !s_axi_bvalid;
  assign do_write = aw_hold && w_hold && !s_axi_bvalid;
  assign wr_pos = aw_addr[9:2];
  assign wr_win = (aw_addr[11:10] == lsrb_pkg::DATA_WINDOW) && (wr_pos >= 8'(lsrb_pkg::FIRST_POS))
                  && (wr_pos <= 8'(NUM_POS));
  assign wr_seq = (aw_addr == lsrb_pkg::REG_SEQ_DATA);
  assign wr_restart = (aw_addr == lsrb_pkg::REG_SEQ_RESTART);
  assign wr_hit = wr_win || wr_seq || wr_restart || (aw_addr == lsrb_pkg::REG_CTRL)
                  || (aw_addr == lsrb_pkg::REG_OUT_CYCLE) || (aw_addr == lsrb_pkg::REG_RELAY_LO)
                  || (aw_addr == lsrb_pkg::REG_RELAY_HI) || (aw_addr == lsrb_pkg::REG_STATUS);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      aw_addr <= '0;
      w_hold <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= lsrb_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= {s_axi_awaddr[11:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? lsrb_pkg::RESP_OKAY : lsrb_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ******************
  // Data registers
  // ******************
  logic [15:0] regs [1:NUM_POS];
  logic [PW-1:0] rd_ptr;
  logic [PW-1:0] wr_ptr;
  logic wr_ok;
  logic [PW-1:0] wr_target;
  logic rd_seq_take;
  // Writes during startup are dropped: the array keeps its defaults
  assign wr_ok = do_write && ready;
  assign wr_target = wr_seq ? wr_ptr : PW'(wr_pos);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 1; i <= NUM_POS; i++) begin
        regs[i] <= lsrb_pkg::DATA_RESET;
      end
    end else if (wr_ok && (wr_win || wr_seq)) begin
      if (w_strb[0]) begin
        regs[wr_target][7:0] <= w_data[7:0];
      end
      if (w_strb[1]) begin
        regs[wr_target][15:8] <= w_data[15:8];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= lsrb_pkg::CTRL_RESET;
      out_cycle <= lsrb_pkg::OUT_CYCLE_RESET;
    end else if (wr_ok && w_strb[0]) begin
      if (aw_addr == lsrb_pkg::REG_CTRL) begin
        ctrl <= {15'h0000, w_data[lsrb_pkg::CTRL_SLOW_BIT]};
      end
      if (aw_addr == lsrb_pkg::REG_OUT_CYCLE) begin
        out_cycle <= w_data[15:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_ptr <= PW'(lsrb_pkg::FIRST_POS);
      wr_ptr <= PW'(lsrb_pkg::FIRST_POS);
    end else begin
      if (wr_ok && wr_restart) begin
        wr_ptr <= PW'(lsrb_pkg::FIRST_POS);
      end else if (wr_ok && wr_seq) begin
        wr_ptr <= (wr_ptr == PW'(NUM_POS)) ? PW'(lsrb_pkg::FIRST_POS) : wr_ptr + 1'b1;
      end
      if (wr_ok && wr_restart) begin
        rd_ptr <= PW'(lsrb_pkg::FIRST_POS);
      end else if (rd_seq_take) begin
        rd_ptr <= (rd_ptr == PW'(NUM_POS)) ? PW'(lsrb_pkg::FIRST_POS) : rd_ptr + 1'b1;
      end
    end
  end

  // ******************
  // AXI read channel
  // ******************
  logic ar_take;
  logic [11:0] ar_addr;
  logic [7:0] rd_pos;
  logic rd_win;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  assign s_axi_arready = !s_axi_rvalid;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign ar_addr = {s_axi_araddr[11:2], 2'b00};
  assign rd_pos = ar_addr[9:2];
  assign rd_win = (ar_addr[11:10] == lsrb_pkg::DATA_WINDOW) && (rd_pos >= 8'(lsrb_pkg::FIRST_POS))
                  && (rd_pos <= 8'(NUM_POS));
  assign rd_seq_take = ar_take && (ar_addr == lsrb_pkg::REG_SEQ_DATA);
  always_comb begin
    next_rdata = 32'h00000000;
    next_rresp = lsrb_pkg::RESP_OKAY;
    if (rd_win) begin
      next_rdata = {16'h0000, regs[PW'(rd_pos)]};
    end else begin
      case (ar_addr)
        lsrb_pkg::REG_RELAY_LO: next_rdata = {16'h0000, relay[15:0]};
        lsrb_pkg::REG_RELAY_HI: next_rdata = {16'h0000, relay[31:16]};
        lsrb_pkg::REG_CTRL: next_rdata = {16'h0000, ctrl};
        lsrb_pkg::REG_OUT_CYCLE: next_rdata = {16'h0000, out_cycle};
        lsrb_pkg::REG_SEQ_DATA: next_rdata = {16'h0000, regs[rd_ptr]};
        lsrb_pkg::REG_SEQ_RESTART: next_rdata = 32'h00000000;
        lsrb_pkg::REG_STATUS: next_rdata = {16'(rd_ptr), 15'h0000, ready};
        default: next_rresp = lsrb_pkg::RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= lsrb_pkg::RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ******************
  // Checks
  // ******************
  sequence s_wr_pair;
    aw_hold && w_hold && !s_axi_bvalid;
  endsequence
  sequence s_restart;
    wr_ok && wr_restart;
  endsequence
  a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    s_wr_pair |=> s_axi_bvalid && !aw_hold && !w_hold)
    else $error("write not answered");
  a_seq_restart: assert property (@(posedge aclk) disable iff (!aresetn)
    s_restart |=> (rd_ptr == PW'(1)) && (wr_ptr == PW'(1)))
    else $error("restart did not reach position one");
  a_seq_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_seq_take && !(wr_ok && wr_restart) && rd_ptr == PW'(NUM_POS)) |=> rd_ptr == PW'(1))
    else $error("read pointer did not wrap");
  a_ready_relay: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == lsrb_pkg::ST_INIT) |-> !relay[15] && !module_ready)
    else $error("ready shown during startup");
  a_startup_end: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == lsrb_pkg::ST_INIT && ms_tick && boot_ms == BW'(STARTUP_MS - 1)) |=> ready ##1 ready)
    else $error("startup did not finish on time");
  a_init_drop: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_write && !ready) |=> $stable(wr_ptr) && $stable(ctrl) && $stable(out_cycle))
    else $error("startup write not dropped");
  a_irq_edge: assert property (@(posedge aclk) disable iff (!aresetn)
    ##2 irq_event == ($past(relay) & ~$past(relay, 2) & lsrb_pkg::IRQ_CAPABLE))
    else $error("interrupt does not follow relay edge");
  a_irq_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
    (irq_event & ~lsrb_pkg::IRQ_CAPABLE) == 32'h00000000)
    else $error("interrupt from non-capable relay");
  a_in_refresh: assert property (@(posedge aclk) disable iff (!aresetn)
    !in_tick |=> $stable(relay_q & ~lsrb_pkg::HC_MASK))
    else $error("relay changed between samples");
  a_out_refresh: assert property (@(posedge aclk) disable iff (!aresetn)
    !out_tick |=> $stable(relay_q & lsrb_pkg::HC_MASK))
    else $error("output relay changed between refreshes");
  a_status_read: assert property (@(posedge aclk) disable iff (!aresetn)
    (ar_take && ar_addr == lsrb_pkg::REG_RELAY_LO) |=> s_axi_rvalid && s_axi_rdata[15:0] == $past(relay[15:0]))
    else $error("relay word mismatch");
endmodule

//--- lsrb_pkg.sv
/*
 * Shared constants and types of the loop status relay bank.
 * Assumes a 100 MHz clock and a 32-bit AXI4-Lite register bus.
 */
package lsrb_pkg;
  // ***************
  // Register map
  // ***************
  localparam int ADDR_W = 12;
  localparam logic [11:0] REG_RELAY_LO = 12'h000;
  localparam logic [11:0] REG_RELAY_HI = 12'h004;
  localparam logic [11:0] REG_CTRL = 12'h008;
  localparam logic [11:0] REG_OUT_CYCLE = 12'h00c;
  localparam logic [11:0] REG_SEQ_DATA = 12'h010;
  localparam logic [11:0] REG_SEQ_RESTART = 12'h014;
  localparam logic [11:0] REG_STATUS = 12'h018;
  localparam logic [1:0] DATA_WINDOW = 2'h1;
  localparam int CTRL_SLOW_BIT = 0;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] OUT_CYCLE_RESET = 16'h001e;
  localparam logic [15:0] DATA_RESET = 16'h0000;
  localparam int NUM_POS = 64;
  localparam int FIRST_POS = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ***************
  // Relay layout
  // ***************
  localparam logic [31:0] IRQ_CAPABLE = 32'hcbcbcbcb;
  localparam logic [31:0] HC_MASK = 32'h30303030;
  localparam logic [31:0] READY_MASK = 32'h00008000;
  localparam int READY_BIT = 15;
  // ***************
  // Timing
  // ***************
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam int STARTUP_MS = 2000;
  localparam int SAMPLE_FAST_MS = 100;
  localparam int SAMPLE_SLOW_MS = 200;
  localparam int OUT_MIN_MS = 10;
  // ***************
  // Types
  // ***************
  typedef struct packed {
    logic fault_flag;
    logic cool_output_state;
    logic heat_output_state;
    logic autotune_done;
    logic manual_mode;
    logic alarm_two_flag;
    logic alarm_one_flag;
  } lsrb_loop_s;
  typedef enum logic [1:0] {
    ST_INIT = 2'b01,
    ST_READY = 2'b10
  } lsrb_state_e;
endpackage

//--- lsrb_cpu_model.sv
/*
 * Host CPU model: an AXI4-Lite master with blocking access tasks.
 * Assumes the bench calls its tasks from one process at a time.
 */
`timescale 1ns/1ps
module lsrb_cpu_model (
  // Clock
  input wire logic aclk,
  // Write channels
  output logic [11:0] awaddr = 12'h000,
  output logic awvalid = 1'b0,
  input wire logic awready,
  output logic [31:0] wdata = 32'h00000000,
  output logic [3:0] wstrb = 4'h0,
  output logic wvalid = 1'b0,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready = 1'b0,
  // Read channels
  output logic [11:0] araddr = 12'h000,
  output logic arvalid = 1'b0,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready = 1'b0,
  // Startup status
  input wire logic module_ready
);
  // ***************
  // Bus cycles
  // ***************
  // Handshakes are sampled at the falling edge, so the value seen is the one the next rising edge takes.
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ha, hw, hb;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid && bready;
      r = bresp;
      @(posedge aclk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
    end while (!hb);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ha, hr;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      ha = arvalid && arready;
      hr = rvalid && rready;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ha) arvalid <= 1'b0;
    end while (!hr);
    rready <= 1'b0;
  endtask

  // ***************
  // Startup gate
  // ***************
  task automatic wait_ready(output int n);
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (module_ready !== 1'b1 && n < 1000);
  endtask
endmodule

//--- loop_status_relay_bank_tb_top.sv
/*
 * Self-checking bench of the relay bank with a host CPU model.
 * Assumes shortened ms and startup counts set by parameters here.
 */
`timescale 1ns/1ps
module loop_status_relay_bank_tb_top;
  // ***************
  // Signals
  // ***************
  localparam int MSC = 10;
  localparam int SUMS = 3;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, irq_event;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  lsrb_pkg::lsrb_loop_s [3:0] loop_in = '0;
  logic command_done = 1'b0;
  logic setup_mode = 1'b0;
  logic setpoint_save_done = 1'b0;
  logic module_ready, irq_req;
  logic [31:0] irq_seen = 32'h00000000;
  logic req_seen = 1'b0;
  logic irq_clr = 1'b0;
  int miscompares = 0;
  int tests_run = 0;
  logic [31:0] d;
  logic [1:0] r;

  always #5 aclk = ~aclk;

  lsrb_top #(.NUM_POS(64), .MS_CYCLES(MSC), .STARTUP_MS(SUMS)) u_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .loop_in(loop_in), .command_done(command_done), .setup_mode(setup_mode),
    .setpoint_save_done(setpoint_save_done),
    .module_ready(module_ready), .irq_event(irq_event), .irq_req(irq_req)
  );

  lsrb_cpu_model u_cpu (
    .aclk(aclk),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .module_ready(module_ready)
  );

  // Sticky capture so a one-cycle pulse is never missed between polls
  always @(posedge aclk) begin
    if (irq_clr) begin
      irq_seen <= 32'h00000000;
      req_seen <= 1'b0;
    end else begin
      irq_seen <= irq_seen | irq_event;
      req_seen <= req_seen | irq_req;
    end
  end

  // ***************
  // Helpers
  // ***************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic set_in(input logic [27:0] l, input logic [2:0] s);
    @(posedge aclk);
    loop_in <= l;
    {setpoint_save_done, setup_mode, command_done} <= s;
  endtask

  function automatic logic [31:0] relay_exp(input logic [27:0] l, input logic [2:0] s);
    relay_exp = {s[2], l[27:21], s[1], l[20:14], 1'b1, l[13:7], s[0], l[6:0]};
  endfunction

  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ***************
  // Scenarios
  // ***************
  task automatic t_startup();
    int n;
    chk({31'h0, module_ready}, 32'h00000000);
    u_cpu.wr(12'h404, 32'h00001234, r); // Write before ready is dropped
    u_cpu.wait_ready(n);
    chk({31'h0, n <= SUMS * MSC + 6}, 32'h00000001);
    u_cpu.rd(lsrb_pkg::REG_STATUS, d, r);
    chk({31'h0, d[0]}, 32'h00000001);
    u_cpu.rd(lsrb_pkg::REG_RELAY_LO, d, r);
    chk(d, 32'h00008000);
    u_cpu.rd(12'h404, d, r);
    chk(d, 32'h00000000);
    $display("test startup done");
  endtask

  task automatic relay_case(input logic [27:0] l, input logic [2:0] s, input int w);
    logic [31:0] e;
    e = relay_exp(l, s);
    set_in(l, s);
    cyc(w);
    u_cpu.rd(lsrb_pkg::REG_RELAY_LO, d, r);
    chk(d, {16'h0000, e[15:0]});
    u_cpu.rd(lsrb_pkg::REG_RELAY_HI, d, r);
    chk(d, {16'h0000, e[31:16]});
  endtask

  task automatic t_relays();
    relay_case({7'h00, 7'h7f, 7'h02, 7'h41}, 3'b101, 100 * MSC + 20);
    u_cpu.wr(lsrb_pkg::REG_CTRL, 32'h00000001, r);
    relay_case({7'h01, 7'h00, 7'h7d, 7'h3e}, 3'b010, 200 * MSC + 20);
    u_cpu.wr(lsrb_pkg::REG_CTRL, 32'h00000000, r);
    $display("test relays done");
  endtask

  task automatic t_seq();
    u_cpu.wr(lsrb_pkg::REG_SEQ_RESTART, 32'h00000000, r);
    for (int i = 0; i < 3; i++) u_cpu.wr(lsrb_pkg::REG_SEQ_DATA, 32'h0000a000 + i, r);
    u_cpu.wr(lsrb_pkg::REG_SEQ_RESTART, 32'h00000000, r);
    u_cpu.wr(12'h408, 32'h0000b0b0, r);
    u_cpu.rd(12'h404, d, r);
    chk(d, 32'h0000a000);
    for (int i = 0; i < 3; i++) begin
      u_cpu.rd(lsrb_pkg::REG_SEQ_DATA, d, r);
      chk(d, (i == 1) ? 32'h0000b0b0 : 32'h0000a000 + i);
    end
    u_cpu.rd(lsrb_pkg::REG_STATUS, d, r);
    chk(d, 32'h00040001);
    $display("test sequential done");
  endtask

  task automatic t_irq();
    set_in(28'h0, 3'b000);
    cyc(100 * MSC + 20);
    irq_clr <= 1'b1;
    cyc(1);
    irq_clr <= 1'b0;
    set_in({7'h00, 7'h00, 7'h34, 7'h00}, 3'b000);
    cyc(100 * MSC + 20);
    chk({req_seen, irq_seen[30:0]}, 32'h00000000);
    set_in({7'h00, 7'h00, 7'h34, 7'h4b}, 3'b010);
    cyc(100 * MSC + 20);
    chk(irq_seen, 32'h0080004b);
    chk({31'h0, req_seen}, 32'h00000001);
    $display("test interrupt done");
  endtask

  task automatic t_errs();
    u_cpu.rd(12'h300, d, r);
    chk({r, d[29:0]}, {lsrb_pkg::RESP_SLVERR, 30'h0});
    u_cpu.wr(lsrb_pkg::REG_RELAY_LO, 32'h0000ffff, r);
    chk({30'h0, r}, {30'h0, lsrb_pkg::RESP_OKAY});
    u_cpu.rd(lsrb_pkg::REG_RELAY_LO, d, r);
    chk(d, 32'h0000b44b);
    u_cpu.wr(lsrb_pkg::REG_OUT_CYCLE, 32'h00000005, r);
    u_cpu.rd(lsrb_pkg::REG_OUT_CYCLE, d, r);
    chk(d, 32'h00000005);
    $display("test errors done");
  endtask

  // ***************
  // Run
  // ***************
  initial begin
    cyc(8);
    aresetn <= 1'b1;
    t_startup();
    t_relays();
    t_seq();
    t_irq();
    t_errs();
    results();
  end

  initial begin
    cyc(20000);
    miscompares++;
    results();
  end
endmodule
